// ### hw/cts_cond.v
// One condition evaluator of the conditional table selector
`timescale 1ns/1ps
`include "cts_defines.vh"

module cts_cond (
    input wire clock,
    input wire rstn,
    input wire arg1_used,
    input wire [`CTS_DW-1:0] arg1_value,
    input wire arg1_error,
    input wire arg2_is_const,
    input wire arg2_used,
    input wire [`CTS_DW-1:0] arg2_value,
    input wire arg2_error,
    input wire [`CTS_DW-1:0] const_value,
    input wire [2:0] op,
    output reg [1:0] result_q
);

// ============================================================
// Argument selection
wire [`CTS_DW-1:0] b_val;
wire b_used;
wire b_err;
reg cmp;
reg [1:0] result_d;

assign b_used = arg2_is_const | arg2_used;
assign b_val = arg2_is_const ? const_value : arg2_value;
assign b_err = arg2_is_const ? 1'b0 : arg2_error;

// ============================================================
// Compare and classify
always @* begin
    case (op)
        `CTS_OP_EQ: cmp = (arg1_value == b_val);
        `CTS_OP_NE: cmp = (arg1_value != b_val);
        `CTS_OP_GT: cmp = (arg1_value > b_val);
        `CTS_OP_GE: cmp = (arg1_value >= b_val);
        `CTS_OP_LT: cmp = (arg1_value < b_val);
        `CTS_OP_LE: cmp = (arg1_value <= b_val);
        default: cmp = 1'b0;
    endcase
    if (!arg1_used || !b_used) begin
        result_d = `CTS_RES_NA;
    end else if (arg1_error || b_err) begin
        result_d = `CTS_RES_ERR;
    end else if (cmp) begin
        result_d = `CTS_RES_TRUE;
    end else begin
        result_d = `CTS_RES_FALSE;
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        result_q <= `CTS_RES_NA;
    end else begin
        result_q <= result_d;
    end
end

endmodule // cts_cond

// ### hw/cts_defines.vh
// Constants for the conditional table selector
`ifndef CTS_DEFINES_VH
`define CTS_DEFINES_VH

// ============================================================
// Sizes
`define CTS_DW 16
`define CTS_NTBL 3
`define CTS_NCND 3
`define CTS_NCOND 9

// ============================================================
// Relational operator codes
`define CTS_OP_EQ 3'h0
`define CTS_OP_NE 3'h1
`define CTS_OP_GT 3'h2
`define CTS_OP_GE 3'h3
`define CTS_OP_LT 3'h4
`define CTS_OP_LE 3'h5
`define CTS_OP_RST 3'h0

// ============================================================
// Condition result codes
`define CTS_RES_FALSE 2'h0
`define CTS_RES_TRUE 2'h1
`define CTS_RES_ERR 2'h2
`define CTS_RES_NA 2'h3

// ============================================================
// Combining operator codes and reset values
`define CTS_CMB_DEFAULT 3'h0
`define CTS_CMB_AND3 3'h1
`define CTS_CMB_OR3 3'h2
`define CTS_CMB_ANDOR 3'h3
`define CTS_CMB_ORAND 3'h4
`define CTS_CMB_RST_T1 3'h1
`define CTS_CMB_RST_T2 3'h1
`define CTS_CMB_RST_T3 3'h0

// ============================================================
// Selected table codes
`define CTS_SEL_NONE 2'h0

`endif

// ### hw/cts_selector.v
// Conditional table selector: conditions, table choice, output forward
`timescale 1ns/1ps
`include "cts_defines.vh"

module cts_selector (
    input wire clock,
    input wire rstn,
    input wire logic_enable,
    input wire [`CTS_NCOND-1:0] arg1_used,
    input wire [`CTS_NCOND*`CTS_DW-1:0] arg1_value,
    input wire [`CTS_NCOND-1:0] arg1_error,
    input wire [`CTS_NCOND-1:0] arg2_is_const,
    input wire [`CTS_NCOND-1:0] arg2_used,
    input wire [`CTS_NCOND*`CTS_DW-1:0] arg2_value,
    input wire [`CTS_NCOND-1:0] arg2_error,
    input wire [`CTS_NCOND*`CTS_DW-1:0] const_value,
    input wire op_wr_en,
    input wire [3:0] op_wr_index,
    input wire [2:0] op_wr_data,
    input wire cmb_wr_en,
    input wire [1:0] cmb_wr_index,
    input wire [2:0] cmb_wr_data,
    input wire [`CTS_NTBL*`CTS_DW-1:0] table_value,
    input wire [`CTS_NTBL-1:0] table_source_valid,
    output reg [`CTS_DW-1:0] logic_out_q,
    output reg logic_out_na_q,
    output reg [1:0] selected_table_q,
    output wire [`CTS_NCOND*2-1:0] cond_result,
    output wire [`CTS_NCOND*3-1:0] cond_op,
    output wire [`CTS_NTBL*3-1:0] cmb_op
);

// ============================================================
// Declarations
reg [`CTS_NCOND*3-1:0] op_q;
reg [`CTS_NCOND*3-1:0] op_d;
reg [`CTS_NTBL*3-1:0] cmb_q;
reg [`CTS_NTBL*3-1:0] cmb_d;
reg en_q;
wire [`CTS_NCOND-1:0] both_used;
wire [`CTS_NTBL-1:0] tbl_hit;
reg [1:0] sel_d;
reg [`CTS_DW-1:0] out_d;
reg na_d;
integer i;
integer j;

assign cond_op = op_q;
assign cmb_op = cmb_q;
assign both_used = arg1_used & (arg2_used | arg2_is_const);

// ============================================================
// Enable register
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        en_q <= 1'b0;
    end else begin
        en_q <= logic_enable;
    end
end

// ============================================================
// Condition operator store
always @* begin
    op_d = op_q;
    for (i = 0; i < `CTS_NCOND; i = i + 1) begin
        if (!both_used[i]) begin
            op_d[i*3 +: 3] = `CTS_OP_RST;
        end else if (op_wr_en && op_wr_index == i[3:0]) begin
            if (op_wr_data <= `CTS_OP_LE) begin
                op_d[i*3 +: 3] = op_wr_data;
            end
        end
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        op_q <= {`CTS_NCOND{`CTS_OP_RST}};
    end else begin
        op_q <= op_d;
    end
end

// ============================================================
// Combining operator store
always @* begin
    cmb_d = cmb_q;
    for (j = 0; j < `CTS_NTBL; j = j + 1) begin
        if (cmb_wr_en && cmb_wr_index == j[1:0]) begin
            if (cmb_wr_data <= `CTS_CMB_ORAND) begin
                cmb_d[j*3 +: 3] = cmb_wr_data;
            end
        end
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        cmb_q <= {`CTS_CMB_RST_T3, `CTS_CMB_RST_T2,
            `CTS_CMB_RST_T1};
    end else begin
        cmb_q <= cmb_d;
    end
end

// ============================================================
// Condition evaluators, three per table
genvar g;
generate
    for (g = 0; g < `CTS_NCOND; g = g + 1) begin : g_cond
        cts_cond u_cond (
            .clock(clock),
            .rstn(rstn),
            .arg1_used(arg1_used[g]),
            .arg1_value(arg1_value[g*`CTS_DW +: `CTS_DW]),
            .arg1_error(arg1_error[g]),
            .arg2_is_const(arg2_is_const[g]),
            .arg2_used(arg2_used[g]),
            .arg2_value(arg2_value[g*`CTS_DW +: `CTS_DW]),
            .arg2_error(arg2_error[g]),
            .const_value(const_value[g*`CTS_DW +: `CTS_DW]),
            .op(op_q[g*3 +: 3]),
            .result_q(cond_result[g*2 +: 2])
        );
    end
endgenerate

// ============================================================
// Table selection test
function tbl_test;
    input [2:0] cmb;
    input [1:0] condition_one_result;
    input [1:0] condition_two_result;
    input [1:0] condition_three_result;
    reg t1;
    reg t2;
    reg t3;
    reg p1;
    reg p2;
    reg p3;
    begin
        t1 = (condition_one_result == `CTS_RES_TRUE);
        t2 = (condition_two_result == `CTS_RES_TRUE);
        t3 = (condition_three_result == `CTS_RES_TRUE);
        p1 = t1 | (condition_one_result == `CTS_RES_NA);
        p2 = t2 | (condition_two_result == `CTS_RES_NA);
        p3 = t3 | (condition_three_result == `CTS_RES_NA);
        case (cmb)
            `CTS_CMB_DEFAULT: tbl_test = 1'b1;
            `CTS_CMB_AND3: tbl_test = p1 & p2 & p3;
            `CTS_CMB_OR3: tbl_test = t1 | t2 | t3;
            `CTS_CMB_ANDOR: tbl_test = (t1 & t2) | t3;
            `CTS_CMB_ORAND: tbl_test = (t1 | t2) & t3;
            default: tbl_test = 1'b0;
        endcase
    end
endfunction

generate
    for (g = 0; g < `CTS_NTBL; g = g + 1) begin : g_tbl
        assign tbl_hit[g] = tbl_test(cmb_q[g*3 +: 3],
            cond_result[g*6 +: 2],
            cond_result[g*6+2 +: 2],
            cond_result[g*6+4 +: 2]);
    end
endgenerate

// ============================================================
// Priority choice and output forward
always @* begin
    sel_d = `CTS_SEL_NONE;
    out_d = {`CTS_DW{1'b0}};
    na_d = 1'b1;
    if (!en_q) begin
        sel_d = `CTS_SEL_NONE;
    end else if (tbl_hit[0]) begin
        sel_d = 2'h1;
    end else if (tbl_hit[1]) begin
        sel_d = 2'h2;
    end else if (tbl_hit[2]) begin
        sel_d = 2'h3;
    end
    if (sel_d != `CTS_SEL_NONE) begin
        if (table_source_valid[sel_d - 2'h1]) begin
            out_d = table_value[(sel_d - 2'h1)*`CTS_DW +: `CTS_DW];
            na_d = 1'b0;
        end else begin
            na_d = 1'b1;
        end
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        selected_table_q <= `CTS_SEL_NONE;
        logic_out_q <= {`CTS_DW{1'b0}};
        logic_out_na_q <= 1'b1;
    end else begin
        selected_table_q <= sel_d;
        logic_out_q <= out_d;
        logic_out_na_q <= na_d;
    end
end

endmodule // cts_selector

// ### verification/cts_checker.sv
// Assertion checker for the conditional table selector
`timescale 1ns/1ps
module cts_checker (
    input wire clock,
    input wire rstn,
    input wire logic_enable,
    input wire [8:0] arg1_used,
    input wire [8:0] arg2_used,
    input wire [8:0] arg2_is_const,
    input wire op_wr_en,
    input wire [3:0] op_wr_index,
    input wire [2:0] op_wr_data,
    input wire cmb_wr_en,
    input wire [1:0] cmb_wr_index,
    input wire [2:0] cmb_wr_data,
    input wire [47:0] table_value,
    input wire [2:0] table_source_valid,
    input wire [15:0] logic_out_q,
    input wire logic_out_na_q,
    input wire [1:0] selected_table_q,
    input wire [17:0] cond_result,
    input wire [26:0] cond_op,
    input wire [8:0] cmb_op
);
    reg en_q;
    reg [47:0] tv_q;
    reg [2:0] sv_q;
    wire [1:0] ix = selected_table_q - 2'h1;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            en_q <= 1'b0;
        end else begin
            en_q <= logic_enable;
        end
    end
    always @(posedge clock) begin
        tv_q <= table_value;
        sv_q <= table_source_valid;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ========================================
    // Checks
    chk_disabled_idle: assert property (
        !$past(logic_enable, 2) |-> selected_table_q == 2'h0
        && logic_out_na_q && logic_out_q == 16'h0000) else $error("not idle");
    chk_forward_value: assert property (
        selected_table_q != 2'h0 && sv_q[ix] |-> !logic_out_na_q
        && logic_out_q == tv_q[ix*16 +: 16]) else $error("bad forward");
    chk_no_source_na: assert property (
        selected_table_q != 2'h0 && !sv_q[ix] |-> logic_out_na_q)
        else $error("no source not flagged");
    chk_cond_na: assert property (!arg1_used[0] |=>
        cond_result[1:0] == 2'h3) else $error("unused not n/a");
    chk_op_forced_eq: assert property (!arg1_used[0] |=>
        cond_op[2:0] == 3'h0) else $error("op not equal");
    chk_op_refused: assert property (op_wr_en && op_wr_index == 4'h0
        && op_wr_data > 3'h5 && arg1_used[0] && (arg2_used[0]
        | arg2_is_const[0]) |=> $stable(cond_op)) else $error("op taken");
    chk_cmb_refused: assert property (cmb_wr_en && (cmb_wr_index
        == 2'h3 || cmb_wr_data > 3'h4) |=> $stable(cmb_op))
        else $error("cmb taken");
    chk_and_select: assert property (en_q && cmb_op[2:0] == 3'h1
        && cond_result[0] && cond_result[2] && cond_result[4]
        |=> selected_table_q == 2'h1) else $error("and not selected");
    chk_default_first: assert property (en_q && cmb_op[2:0] == 3'h0
        |=> selected_table_q == 2'h1) else $error("default missed");
    cover property (selected_table_q == 2'h3);
    cover property (op_wr_en && op_wr_data > 3'h5);
    cover property (selected_table_q != 2'h0 && logic_out_na_q);
endmodule // cts_checker

bind cts_selector cts_checker i_cts_checker (.clock, .rstn, .logic_enable,
    .arg1_used, .arg2_used, .arg2_is_const, .op_wr_en, .op_wr_index,
    .op_wr_data, .cmb_wr_en, .cmb_wr_index, .cmb_wr_data, .table_value,
    .table_source_valid, .logic_out_q, .logic_out_na_q, .selected_table_q,
    .cond_result, .cond_op, .cmb_op);

// ### verification/tb_cts_selector.sv
// Testbench for the conditional table selector
`timescale 1ns/1ps
module tb_cts_selector;
    reg clock, rstn, logic_enable, op_wr_en, cmb_wr_en;
    reg [8:0] arg1_used, arg1_error, arg2_is_const, arg2_used, arg2_error;
    reg [143:0] arg1_value, arg2_value, const_value;
    reg [3:0] op_wr_index;
    reg [2:0] op_wr_data, cmb_wr_data, table_source_valid;
    reg [1:0] cmb_wr_index;
    reg [47:0] table_value;
    wire [15:0] logic_out_q;
    wire logic_out_na_q;
    wire [1:0] selected_table_q;
    wire [17:0] cond_result;
    wire [26:0] cond_op;
    wire [8:0] cmb_op;
    integer fail_count, tests_run, cyc, k;
    cts_selector i_cts_selector (.clock, .rstn, .logic_enable, .arg1_used,
        .arg1_value, .arg1_error, .arg2_is_const, .arg2_used, .arg2_value,
        .arg2_error, .const_value, .op_wr_en, .op_wr_index, .op_wr_data,
        .cmb_wr_en, .cmb_wr_index, .cmb_wr_data, .table_value,
        .table_source_valid, .logic_out_q, .logic_out_na_q,
        .selected_table_q, .cond_result, .cond_op, .cmb_op);
    // ========================================
    // Tasks
    task give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input [47:0] got, input [47:0] exp, input [63:0] nm);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input integer c, input integer i, input [2:0] d);
        @(posedge clock);
        op_wr_en <= (c == 0);
        cmb_wr_en <= (c != 0);
        op_wr_index <= i[3:0];
        cmb_wr_index <= i[1:0];
        op_wr_data <= d;
        cmb_wr_data <= d;
        @(posedge clock);
        op_wr_en <= 1'b0;
        cmb_wr_en <= 1'b0;
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end
    // ========================================
    // Tests
    initial begin
        {rstn, logic_enable, op_wr_en, cmb_wr_en} = 4'h0;
        {arg1_used, arg1_error, arg2_is_const, arg2_used, arg2_error} = 45'h0;
        {arg1_value, arg2_value, const_value} = 432'h0;
        {op_wr_index, op_wr_data, cmb_wr_data, cmb_wr_index} = 12'h0;
        table_value = 48'h3333_2222_1111;
        table_source_valid = 3'h7;
        fail_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        #1;
        chk(cmb_op, 9'h009, "cmb_op");
        chk(cond_result, 18'h3_ffff, "result");
        chk(selected_table_q, 2'h0, "sel");
        $display("Test reset done");
        @(posedge clock);
        logic_enable <= 1'b1;
        tick(3);
        chk(selected_table_q, 2'h1, "sel");
        chk(logic_out_q, 16'h1111, "out");
        wr(0, 0, 3'h4);
        tick(1);
        chk(cond_op, 27'h0, "cond_op");
        @(posedge clock);
        arg1_used <= 9'h001;
        arg2_is_const <= 9'h001;
        arg1_value <= 144'h5;
        const_value <= 144'h7;
        for (k = 0; k < 7; k = k + 1) begin
            wr(0, 0, k[2:0]);
            tick(2);
            chk(cond_op[2:0], (k < 6) ? k : 5, "op");
            chk(cond_result[1:0], (7'h72 >> k) & 7'h1, "result");
        end
        $display("Test operators done");
        @(posedge clock);
        arg1_error <= 9'h001;
        tick(3);
        chk(cond_result[1:0], 2'h2, "result");
        chk(selected_table_q, 2'h2, "sel");
        wr(1, 1, 3'h2);
        tick(3);
        chk(selected_table_q, 2'h3, "sel");
        chk(logic_out_q, 16'h3333, "out");
        @(posedge clock);
        arg1_error <= 9'h000;
        for (k = 0; k < 5; k = k + 1) begin
            wr(1, 0, k[2:0]);
            tick(3);
            chk(selected_table_q, (10'h3d5 >> 2 * k) & 10'h3, "sel");
        end
        wr(1, 3, 3'h1);
        wr(1, 0, 3'h5);
        tick(1);
        chk(cmb_op, 9'h014, "cmb_op");
        $display("Test combining done");
        @(posedge clock);
        table_source_valid <= 3'h3;
        tick(2);
        chk(logic_out_na_q, 1'b1, "na");
        @(posedge clock);
        table_source_valid <= 3'h7;
        table_value <= 48'h4444_2222_1111;
        tick(2);
        chk(logic_out_q, 16'h4444, "out");
        $display("Test table done");
        @(posedge clock);
        arg1_used <= 9'h005;
        arg2_used <= 9'h004;
        tick(3);
        chk(cond_result[5:4], 2'h1, "result");
        chk(selected_table_q, 2'h1, "sel");
        @(posedge clock);
        arg2_error <= 9'h004;
        tick(3);
        chk(cond_result[5:4], 2'h2, "result");
        chk(selected_table_q, 2'h3, "sel");
        @(posedge clock);
        arg2_error <= 9'h000;
        arg1_error <= 9'h001;
        wr(1, 0, 3'h3);
        tick(3);
        chk(selected_table_q, 2'h1, "sel");
        chk(logic_out_q, 16'h1111, "out");
        $display("Test mixed done");
        @(posedge clock);
        logic_enable <= 1'b0;
        tick(3);
        chk(selected_table_q, 2'h0, "sel");
        chk(logic_out_na_q, 1'b1, "na");
        $display("Test disable done");
        give_verdict;
    end
endmodule // tb_cts_selector
